// ### rtl/cmpif_top.sv
// Comparator interface: config, enables, edge flags and sampled comparator results
//
// Function
// - Comparator zero runs only with config bit 0; comparator one with bit 8.
// - Comparator zero positive input selected by config bits 6:4.
// - Comparator zero negative input selected by config bits 3:1.
// - Comparator one positive input selected by bits 14:12, same codes.
// - Comparator one negative input selected by config bits 11:9.
// - Bit 18 picks internal reference: 1 threshold DAC, 0 bandgap.
// - Bits 17:15 set the threshold DAC level for comparator zero.
// - Interrupt enable register holds four enables, reset to zero.
// - Rising output edge sets flag bit 0 or bit 2.
// - Falling output edge sets flag bit 1 or bit 3.
// - Writing one clears a flag unless an edge sets it in the same cycle; zero leaves it; flags reset to zero.
// - Read-only output register shows both comparator results in bits 1:0.
// - Comparators are sampled on the system clock, three clock latency.
// - Output forced to zero while a comparator's inputs are disabled.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module cmpif_top
  import cmpif_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic [1:0]  comparator_raw,
  output logic             comparator_zero_enable,
  output logic      [2:0]  comparator_zero_positive_select,
  output logic      [2:0]  comparator_zero_negative_select,
  output logic             comparator_one_enable,
  output logic      [2:0]  comparator_one_positive_select,
  output logic      [2:0]  comparator_one_negative_select,
  output logic             ref_source_select,
  output logic      [2:0]  threshold_dac_level,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] config_ff;
  logic [3:0]  irq_enable_ff;
  logic [3:0]  flags_ff;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic [1:0]  result_ff;
  logic [1:0]  result_prev_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic sel_output = (reg_addr == CMPIF_OUTPUT_OFS);
  wire logic sel_config = (reg_addr == CMPIF_CONFIG_OFS);
  wire logic sel_enable = (reg_addr == CMPIF_IRQ_ENABLE_OFS);
  wire logic sel_flags  = (reg_addr == CMPIF_IRQ_FLAGS_OFS);

  wire logic wr_config = reg_write & sel_config;
  wire logic wr_enable = reg_write & sel_enable;
  wire logic wr_flags  = reg_write & sel_flags;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator qualification, edge flags, read data and interrupt
  wire logic [2:0] c0_pos = config_ff[CMPIF_C0_POS_LSB +: 3];
  wire logic [2:0] c0_neg = config_ff[CMPIF_C0_NEG_LSB +: 3];
  wire logic [2:0] c1_pos = config_ff[CMPIF_C1_POS_LSB +: 3];
  wire logic [2:0] c1_neg = config_ff[CMPIF_C1_NEG_LSB +: 3];

  wire logic c0_live = config_ff[CMPIF_C0_EN_POS] &
                       (c0_pos != CMPIF_SEL_DISABLED) & (c0_neg != CMPIF_SEL_DISABLED);
  wire logic c1_live = config_ff[CMPIF_C1_EN_POS] &
                       (c1_pos != CMPIF_SEL_DISABLED) & (c1_neg != CMPIF_SEL_DISABLED);
  wire logic [1:0] live = {c1_live, c0_live};

  wire logic [1:0] rise = result_ff & ~result_prev_ff;
  wire logic [1:0] fall = ~result_ff & result_prev_ff;
  wire logic [3:0] events = {fall[1], rise[1], fall[0], rise[0]};

  wire logic [3:0] clr_mask = wr_flags ? reg_wdata[3:0] : 4'h0;
  wire logic [3:0] nxt_flags = (flags_ff & ~clr_mask) | events;

  wire logic [31:0] nxt_config = reg_wdata & CMPIF_CONFIG_MASK;

  wire logic [31:0] nxt_rdata =
      sel_output ? {30'h0, result_ff} :
      sel_config ? config_ff :
      sel_enable ? {28'h0, irq_enable_ff} :
      sel_flags  ? {28'h0, flags_ff} : 32'h0;

  wire logic nxt_irq = |(nxt_flags & irq_enable_ff);

  ////////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_ff <= CMPIF_CONFIG_RESET;
    end else if (clk_en && wr_config) begin
      config_ff <= nxt_config;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_enable_ff <= CMPIF_IRQ_EN_RESET;
    end else if (clk_en && wr_enable) begin
      irq_enable_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_ff       <= 2'h0;
      sync2_ff       <= 2'h0;
      result_ff      <= 2'h0;
      result_prev_ff <= 2'h0;
    end else if (clk_en) begin
      sync1_ff       <= comparator_raw;
      sync2_ff       <= sync1_ff;
      result_ff      <= sync2_ff & live;
      result_prev_ff <= result_ff;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_ff  <= CMPIF_FLAGS_RESET;
      rdata_ff  <= 32'h0;
      irq_ff    <= 1'h0;
    end else if (clk_en) begin
      flags_ff  <= nxt_flags;
      rdata_ff  <= reg_read ? nxt_rdata : 32'h0;
      irq_ff    <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata                       = rdata_ff;
  assign irq                             = irq_ff;
  assign comparator_zero_enable          = config_ff[CMPIF_C0_EN_POS];
  assign comparator_zero_positive_select = c0_pos;
  assign comparator_zero_negative_select = c0_neg;
  assign comparator_one_enable           = config_ff[CMPIF_C1_EN_POS];
  assign comparator_one_positive_select  = c1_pos;
  assign comparator_one_negative_select  = c1_neg;
  assign ref_source_select               = config_ff[CMPIF_REFSEL_POS];
  assign threshold_dac_level             = config_ff[CMPIF_DAC_LSB +: 3];

endmodule

// ### rtl/cmpif_pkg.sv
// Package: register map, field layout and reset values of the comparator interface
package cmpif_pkg;
  localparam logic [31:0] CMPIF_OUTPUT_OFS     = 32'h40600000;
  localparam logic [31:0] CMPIF_CONFIG_OFS     = 32'h40600004;
  localparam logic [31:0] CMPIF_IRQ_ENABLE_OFS = 32'h40600008;
  localparam logic [31:0] CMPIF_IRQ_FLAGS_OFS  = 32'h4060000C;

  localparam int CMPIF_C0_EN_POS    = 0;
  localparam int CMPIF_C0_NEG_LSB   = 1;
  localparam int CMPIF_C0_POS_LSB   = 4;
  localparam int CMPIF_C1_EN_POS    = 8;
  localparam int CMPIF_C1_NEG_LSB   = 9;
  localparam int CMPIF_C1_POS_LSB   = 12;
  localparam int CMPIF_DAC_LSB      = 15;
  localparam int CMPIF_REFSEL_POS   = 18;

  localparam logic [31:0] CMPIF_CONFIG_MASK   = 32'h0007FF7F;
  localparam logic [31:0] CMPIF_CONFIG_RESET  = 32'h00000000;
  localparam logic [3:0]  CMPIF_IRQ_EN_RESET  = 4'h0;
  localparam logic [3:0]  CMPIF_FLAGS_RESET   = 4'h0;

  localparam logic [2:0] CMPIF_SEL_DISABLED  = 3'h0;
  localparam logic [2:0] CMPIF_SEL_INT_REF   = 3'h5;
  localparam logic [2:0] CMPIF_SEL_HALF_VDD  = 3'h6;
  localparam logic       CMPIF_REF_DAC       = 1'h1;
endpackage

// ### bench/cmpif_partner.sv
// Model of the two analog comparators behind the block
`timescale 1ns/1ps
module cmpif_partner (
  input  wire logic       mclk,
  input  wire logic [1:0] live,
  input  wire logic [1:0] above,
  output logic      [1:0] raw
);
  logic [1:0] junk_ff = 2'h1;
  // Unpowered or unrouted: output wanders
  always_ff @(posedge mclk) junk_ff <= ~junk_ff;
  assign raw = (live & above) | (~live & junk_ff);
endmodule

// ### bench/cmpif_properties.sv
// Checker of config outputs and register readback
`timescale 1ns/1ps
module cmpif_properties
  import cmpif_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        comparator_zero_enable,
  input wire logic        comparator_one_enable,
  input wire logic [2:0]  comparator_zero_positive_select,
  input wire logic [2:0]  comparator_zero_negative_select,
  input wire logic        ref_source_select,
  input wire logic [2:0]  threshold_dac_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence cfg_wr; clk_en && reg_write && reg_addr == CMPIF_CONFIG_OFS; endsequence
  sequence rd_of(logic [31:0] a); clk_en && reg_read && reg_addr == a; endsequence
  AST_EN: assert property (cfg_wr |=> {comparator_one_enable, comparator_zero_enable} ==
    {$past(reg_wdata[8]), $past(reg_wdata[0])}) else $error("enable bits");
  AST_P0: assert property (cfg_wr |=> comparator_zero_positive_select == $past(reg_wdata[6:4])) else $error("pos");
  AST_N0: assert property (cfg_wr |=> comparator_zero_negative_select == $past(reg_wdata[3:1])) else $error("neg");
  AST_REF: assert property (cfg_wr |=> ref_source_select == $past(reg_wdata[18])) else $error("ref");
  AST_DAC: assert property (cfg_wr |=> threshold_dac_level == $past(reg_wdata[17:15])) else $error("dac");
  AST_RSV: assert property (rd_of(CMPIF_CONFIG_OFS) |=> !reg_rdata[7] && reg_rdata[31:19] == 13'h0) else $error("rsv");
  AST_OUT: assert property (rd_of(CMPIF_OUTPUT_OFS) |=> reg_rdata[31:2] == 30'h0) else $error("out");
  AST_IEN: assert property (rd_of(CMPIF_IRQ_ENABLE_OFS) |=> reg_rdata[31:4] == 28'h0) else $error("ien");
endmodule
bind cmpif_top cmpif_properties chk_i (.*);

// ### bench/comparator_interface_test.sv
// Testbench of the comparator interface
`timescale 1ns/1ps
module comparator_interface_test;
  import cmpif_pkg::*;
  logic mclk = 0, reset = 1, clk_en = 1, reg_write = 0, reg_read = 0, irq, ref_source_select;
  logic comparator_zero_enable, comparator_one_enable;
  logic [2:0] comparator_zero_positive_select, comparator_zero_negative_select, c;
  logic [2:0] comparator_one_positive_select, comparator_one_negative_select, threshold_dac_level;
  logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
  logic [1:0] comparator_raw, above = 0;
  int err_total = 0, tests_run = 0, cyc = 0;
  wire [17:0] pins = {ref_source_select, threshold_dac_level, comparator_one_positive_select,
    comparator_one_negative_select, comparator_one_enable, comparator_zero_positive_select,
    comparator_zero_negative_select, comparator_zero_enable};
  always #12.5 mclk = ~mclk;
  cmpif_top uut (.*);
  cmpif_partner model (.mclk(mclk), .above(above), .raw(comparator_raw),
    .live({comparator_one_enable && |comparator_one_positive_select && |comparator_one_negative_select,
    comparator_zero_enable && |comparator_zero_positive_select && |comparator_zero_negative_select}));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] v);
    @(posedge mclk) {reg_write, reg_addr, reg_wdata} <= {1'h1, a, v};
    @(posedge mclk) reg_write <= 1'h0;
  endtask
  task automatic rd(string name, logic [31:0] a, logic [31:0] e);
    @(posedge mclk) {reg_read, reg_addr} <= {1'h1, a};
    @(posedge mclk) reg_read <= 1'h0;
    #1 chk(name, reg_rdata, e);
  endtask
  task wrap_up;
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc > 1000) begin
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    rd("config", CMPIF_CONFIG_OFS, 32'h0);
    rd("irq enable", CMPIF_IRQ_ENABLE_OFS, 32'h0);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {13'h1FFF, c[0], c, c, c, 2'h3, c, c, 1'h1};
      wr(CMPIF_CONFIG_OFS, d);
      rd("config", CMPIF_CONFIG_OFS, d & 32'h0007FF7F);
      chk("pins", pins, {c[0], c, c, c, 1'h1, c, c, 1'h1});
    end
    wr(CMPIF_CONFIG_OFS, 32'h1313);
    wr(CMPIF_IRQ_ENABLE_OFS, 32'hFFFFFFFF);
    // Drop edges left by enable switching in the loop
    wr(CMPIF_IRQ_FLAGS_OFS, 32'hF);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'h0);
    rd("irq enable", CMPIF_IRQ_ENABLE_OFS, 32'hF);
    above <= 2'h3;
    repeat (6) @(posedge mclk);
    rd("output", CMPIF_OUTPUT_OFS, 32'h3);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'h5);
    chk("irq", irq, 1'h1);
    above <= 2'h0;
    repeat (6) @(posedge mclk);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'hF);
    wr(CMPIF_IRQ_FLAGS_OFS, 32'h5);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'hA);
    wr(CMPIF_IRQ_ENABLE_OFS, 32'h5);
    @(posedge mclk);
    #1 chk("irq", irq, 1'h0);
    wr(CMPIF_IRQ_FLAGS_OFS, 32'hF);
    rd("flags", CMPIF_IRQ_FLAGS_OFS, 32'h0);
    above <= 2'h3;
    wr(CMPIF_CONFIG_OFS, 32'h1303);
    repeat (6) @(posedge mclk);
    rd("output", CMPIF_OUTPUT_OFS, 32'h2);
    rd("unmapped", 32'h40600010, 32'h0);
    wrap_up;
  end
endmodule
